//--- dv/sfo_core_sva.sv
`timescale 1ns/100ps
module sfo_core_sva (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Watched pins and outputs.
  input wire logic        spi_cs_n,
  input wire logic        spi_so_oe_n,
  input wire logic        write_in_progress,
  input wire logic        write_enable_latch,
  input wire logic        erase_req,
  input wire logic        erase_block,
  input wire logic [23:0] erase_addr,
  input wire logic        mem_wr_valid,
  input wire logic        mem_wr_ready,
  input wire logic [23:0] mem_wr_addr,
  input wire logic [7:0]  mem_wr_data
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_start_needs_wel;
    $rose(write_in_progress) |-> $past(write_enable_latch);
  endproperty
  a_start_needs_wel: assert property (p_start_needs_wel) else $error("cycle began without latch");
  property p_start_at_cs_high;
    $rose(write_in_progress) |-> spi_cs_n;
  endproperty
  a_start_at_cs_high: assert property (p_start_at_cs_high) else $error("cycle began in a frame");
  property p_busy_no_wel;
    write_in_progress |-> !write_enable_latch;
  endproperty
  a_busy_no_wel: assert property (p_busy_no_wel) else $error("latch set while busy");
  property p_erase_pulse;
    erase_req |=> !erase_req;
  endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase request too long");
  property p_erase_busy;
    erase_req |-> write_in_progress [*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase outside a cycle");
  property p_erase_align;
    erase_req |-> erase_addr[11:0] == 12'h000 && (!erase_block || erase_addr[14:12] == 3'h0);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase start not aligned");
  property p_wr_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("byte write dropped");
  property p_wr_in_cycle;
    mem_wr_valid |-> write_in_progress;
  endproperty
  a_wr_in_cycle: assert property (p_wr_in_cycle) else $error("byte write while idle");
  property p_so_release;
    spi_cs_n [*6] |-> spi_so_oe_n;
  endproperty
  a_so_release: assert property (p_so_release) else $error("output driven while deselected");
endmodule

bind sfo_core sfo_core_sva u_sva (.clk, .rst, .spi_cs_n, .spi_so_oe_n, .write_in_progress,
  .write_enable_latch, .erase_req, .erase_block, .erase_addr, .mem_wr_valid, .mem_wr_ready,
  .mem_wr_addr, .mem_wr_data);

//--- dv/sfo_core_tb.sv
`timescale 1ns/100ps
`include "sfo_map.svh"
module sfo_core_tb import sfo_pkg::*;;
  // A frame, then whether a cycle and a main-array erase should follow.
  typedef struct {
    int          hb;
    logic [39:0] h;
    logic        busy;
    logic        ers;
    logic [24:0] ea;
  } sfo_row_t;
  // Design pins and bench state.
  logic        clk, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n, write_in_progress;
  logic        write_enable_latch, erase_req, erase_block, mem_wr_valid;
  logic        rst = 1'b1, mem_wr_ready = 1'b0, stall = 1'b0, protect_top_bottom_select = 1'b0;
  logic        protect_granularity_select = 1'b0, otp_area_one_lock = 1'b0;
  logic        otp_area_two_lock = 1'b0, otp_area_three_lock = 1'b0;
  logic [2:0]  protect_level = 3'h0;
  logic [23:0] erase_addr, mem_wr_addr;
  logic [7:0]  mem_wr_data, rxb;
  logic [3:0]  ers_n;
  logic [24:0] ers_v;
  int          err_count, cmp_count;
  sfo_wr_t     wq[$];
  sfo_row_t    rows[7] = '{
    '{32, {`SFO_OP_SECT_ERS, 24'h012345, 8'h00}, 1'b1, 1'b1, {1'b0, 24'h012000}},
    '{32, {`SFO_OP_BLK_ERS, 24'h01ABCD, 8'h00}, 1'b1, 1'b1, {1'b1, 24'h018000}},
    '{31, {`SFO_OP_SECT_ERS, 24'h012345, 8'h00}, 1'b0, 1'b0, 25'h0000000},
    '{33, {`SFO_OP_BLK_ERS, 24'h012345, 8'h00}, 1'b0, 1'b0, 25'h0000000},
    '{8, {`SFO_OP_OTP_ERASE, 32'h00000000}, 1'b1, 1'b0, 25'h0000000},
    '{16, {`SFO_OP_OTP_ERASE, 32'h00000000}, 1'b0, 1'b0, 25'h0000000},
    '{39, {`SFO_OP_PAGE_PROG, 24'h000100, 8'hFF}, 1'b0, 1'b0, 25'h0000000}};

  sfo_core #(.PP_CYCLES(50), .SE_CYCLES(400), .BE_CYCLES(500), .FIFO_DEPTH(8)) uut (
    .clk, .rst, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n, .protect_level,
    .protect_top_bottom_select, .protect_granularity_select, .otp_area_one_lock,
    .otp_area_two_lock, .otp_area_three_lock, .write_in_progress, .write_enable_latch,
    .erase_req, .erase_block, .erase_addr, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr,
    .mem_wr_data);
  sfo_host u_host (.spi_sck, .spi_cs_n, .spi_si, .spi_so);

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The far side takes bytes only every other cycle, or not at all while stalled.
  always @(negedge clk) mem_wr_ready <= stall ? 1'b0 : ~mem_wr_ready;

  // Record every byte handed out and every erase request.
  always @(posedge clk) begin
    if (mem_wr_valid && mem_wr_ready) wq.push_back({mem_wr_addr, mem_wr_data});
    if (erase_req) begin
      ers_n <= ers_n + 4'h1;
      ers_v <= {erase_block, erase_addr};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic send(input int hb, input logic [39:0] h, input int nd, input logic [7:0] d0);
    u_host.frame(hb, h, nd, d0, rxb);
  endtask

  // Polling has a bound, so a stuck cycle ends the run instead of hanging it.
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        err_count++;
        finish_test();
      end
    end
  endtask

  initial begin
    repeat (20) @(negedge clk);
    check(write_in_progress, 1'b0);
    check(spi_so_oe_n, 1'b1);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
      ers_n = 4'h0;
      send(rows[i].hb, rows[i].h, 0, 8'h00);
      check(write_in_progress, rows[i].busy);
      check(write_enable_latch, !rows[i].busy);
      check(ers_n, {3'h0, rows[i].ers});
      if (rows[i].ers) check(ers_v, rows[i].ea);
      wait_idle();
    end
    // Without the latch, and on a protected target, erase is refused.
    send(8, {`SFO_OP_WRDI, 32'h00000000}, 0, 8'h00);
    send(32, {`SFO_OP_SECT_ERS, 24'h012345, 8'h00}, 0, 8'h00);
    check(write_in_progress, 1'b0);
    protect_level = 3'h7;
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    send(32, {`SFO_OP_SECT_ERS, 24'h012345, 8'h00}, 0, 8'h00);
    check(write_in_progress, 1'b0);
    // Status stays readable during a cycle; enabling is ignored while busy.
    protect_level = 3'h0;
    protect_top_bottom_select = 1'b1;
    protect_granularity_select = 1'b1;
    send(32, {`SFO_OP_SECT_ERS, 24'h012345, 8'h00}, 0, 8'h00);
    send(8, {`SFO_OP_RDSR, 32'h00000000}, 1, 8'h00);
    check(rxb, 8'h61);
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    check(write_enable_latch, 1'b0);
    wait_idle();
    check(write_enable_latch, 1'b0);
    // One sector at the bottom is protected; flipping the end frees sector zero.
    protect_level = 3'h1;
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    send(32, {`SFO_OP_SECT_ERS, 24'h000ABC, 8'h00}, 0, 8'h00);
    check(write_in_progress, 1'b0);
    protect_top_bottom_select = 1'b0;
    send(32, {`SFO_OP_SECT_ERS, 24'h000ABC, 8'h00}, 0, 8'h00);
    check(write_in_progress, 1'b1);
    wait_idle();
    protect_level = 3'h0;
    // Locked areas refuse erase and program; an open area takes a byte.
    {otp_area_one_lock, otp_area_two_lock, otp_area_three_lock} = 3'h7;
    wq.delete();
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    send(8, {`SFO_OP_OTP_ERASE, 32'h00000000}, 0, 8'h00);
    check(write_in_progress, 1'b0);
    otp_area_two_lock = 1'b0;
    send(40, {`SFO_OP_OTP_PROG, 24'h000100, 8'h00}, 0, 8'h00);
    check(write_in_progress, 1'b0);
    send(32, {`SFO_OP_OTP_PROG, 24'h000200, 8'h00}, 1, 8'h5A);
    check(write_in_progress, 1'b1);
    wait_idle();
    check(wq.size(), 0);
    send(40, {`SFO_OP_OTP_READ, 24'h0001FF, 8'h00}, 1, 8'h00);
    check(rxb, 8'hFF);
    send(40, {`SFO_OP_OTP_READ, 24'h0001FF, 8'h00}, 2, 8'h00);
    check(rxb, 8'h5A);
    // Page bytes wrap in the page; the stalled stream holds its first byte.
    stall = 1'b1;
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    send(32, {`SFO_OP_PAGE_PROG, 24'h0000FE, 8'h00}, 10, 8'h10);
    repeat (300) @(negedge clk);
    check({mem_wr_valid, write_in_progress}, 2'h3);
    stall = 1'b0;
    wait_idle();
    check(wq.size(), 10);
    check(wq[0], {24'h000000, 8'h12});
    check(wq[9], {24'h0000FF, 8'h11});
    // More than a page: only the last 256 bytes count.
    wq.delete();
    send(8, {`SFO_OP_WREN, 32'h00000000}, 0, 8'h00);
    send(32, {`SFO_OP_PAGE_PROG, 24'h000300, 8'h00}, 258, 8'h00);
    wait_idle();
    check(wq.size(), 256);
    check(wq[0], {24'h000300, 8'hFF});
    check(wq[1], {24'h000301, 8'hFE});
    check(wq[2], {24'h000302, 8'h02});
    finish_test();
  end
endmodule

//--- dv/sfo_host.sv
`timescale 1ns/100ps
module sfo_host (
  // Serial pins toward the device.
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so
);
  // Idle bus: clock low and still, select high.
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end

  // The caller picks the bit count, so short or long frames are deliberate.
  task automatic frame(input int hb, input logic [39:0] h, input int nd, input logic [7:0] d0,
                       output logic [7:0] rx);
    int         i;
    logic [8:0] k;
    logic [7:0] b;
    rx = 8'h00;
    spi_cs_n = 1'b0;
    for (i = 0; i < hb + 8 * nd; i++) begin
      k = 9'((i - hb) / 8);
      b = (d0 + k[7:0]) ^ {8{k[8]}};
      spi_si = (i < hb) ? h[39 - i] : b[7 - (i - hb) % 8];
      #80 spi_sck = 1'b1;
      rx = {rx[6:0], spi_so};
      #80 spi_sck = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    // A released data line shows the inverse, never a stale level.
    spi_si = ~spi_si;
    #320;
  endtask
endmodule

//--- logic/sfo_core.sv
// Overview of operation
// - OTP read: address, dummy byte, rising-edge sampling.
// - OTP read data on falling edges, pointer advances.
// - OTP read pointer wraps 3FF to 000.
// - Three 256-byte OTP areas, selected by A15-A8.
// - Write enable latch required for program/erase.
// - OTP erase only if opcode-only frame.
// - Chip-select rise starts cycle; busy flag held.
// - Enable latch cleared before cycle ends.
// - Status reads answered during busy cycle.
// - Locked OTP areas are never erased.
// - OTP program: 1-256 bytes, page-program time.
// - Per-area lock blocks OTP programming.
// - Page data wraps within the same page.
// - Only final 256 page bytes are programmed.
// - Unsent page bytes stay unchanged.
// - Page program needs whole data bytes.
// - Protected pages, sectors, blocks are refused.
// - Sector erase: any address, whole 4 KB.
// - Sector and block erases need exactly four whole bytes.
// - 32 KB erase: any address, block-erase time.
`timescale 1ns/100ps
`include "sfo_map.svh"
module sfo_core import sfo_pkg::*; #(
  parameter int unsigned PP_CYCLES  = `SFO_T_PP_US * `SFO_CLK_MHZ,
  parameter int unsigned SE_CYCLES  = `SFO_T_SE_US * `SFO_CLK_MHZ,
  parameter int unsigned BE_CYCLES  = `SFO_T_BE_US * `SFO_CLK_MHZ,
  parameter int          FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins.
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_si,
  output logic             spi_so,
  output logic             spi_so_oe_n,
  // Protection and lock settings.
  input  wire logic [2:0]  protect_level,
  input  wire logic        protect_top_bottom_select,
  input  wire logic        protect_granularity_select,
  input  wire logic        otp_area_one_lock,
  input  wire logic        otp_area_two_lock,
  input  wire logic        otp_area_three_lock,
  // Status.
  output logic             write_in_progress,
  output logic             write_enable_latch,
  // Main array erase request.
  output logic             erase_req,
  output logic             erase_block,
  output logic [23:0]      erase_addr,
  // Main array byte writes.
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [23:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data
);
  // A zero count would underflow the end test and stretch timing to 2^32 clocks, so such counts are refused at elaboration.
  if (PP_CYCLES == 0 || SE_CYCLES == 0 || BE_CYCLES == 0) begin
    $error("sfo_core: cycle counts must be at least one");
  end

  // Pin synchronisers, plus a third stage for edge detection.
  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] si_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      si_q  <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], spi_sck};
      cs_q  <= {cs_q[1:0], spi_cs_n};
      si_q  <= {si_q[0], spi_si};
    end
  end

  wire sel     = ~cs_q[1];
  wire sck_up  = sel & sck_q[1] & ~sck_q[2];
  wire sck_dn  = sel & ~sck_q[1] & sck_q[2];
  wire cs_fall = ~cs_q[1] & cs_q[2];
  wire cs_rise = cs_q[1] & ~cs_q[2];

  // Frame receive state.
  logic [2:0]  bit_q;
  logic [6:0]  sh_q;
  logic [9:0]  byte_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [7:0]  ptr_q;
  logic [9:0]  rd_ptr_q;
  logic [7:0]  out_q;
  logic        so_q;
  logic        oe_n_q;
  logic        wel_q;
  logic        wip_q;

  wire [7:0] byte_in  = {sh_q, si_q[1]};
  wire       byte_end = sck_up & (bit_q == 3'h7);
  wire       is_prog  = (op_q == `SFO_OP_PAGE_PROG) | (op_q == `SFO_OP_OTP_PROG);
  wire       data_wr  = byte_end & is_prog & ~wip_q & (byte_q >= `SFO_LEN_ADDR);

  // Data output phase; while busy only status reads answer.
  wire rd_sr  = (op_q == `SFO_OP_RDSR) & (byte_q >= `SFO_LEN_OPCODE);
  wire rd_otp = (op_q == `SFO_OP_OTP_READ) & ~wip_q & (byte_q >= `SFO_LEN_DUMMY);
  wire rd_on  = sel & (rd_sr | rd_otp);

  // Bit and byte counting; every bit is taken on a rising clock edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_q  <= 3'h0;
      sh_q   <= 7'h00;
      byte_q <= 10'h000;
    end else if (cs_fall) begin
      bit_q  <= 3'h0;
      byte_q <= 10'h000;
    end else if (sck_up) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byte_in[6:0];
      if (bit_q == 3'h7 && byte_q != 10'h3FF) begin
        byte_q <= byte_q + 10'h001;
      end
    end
  end

  // Opcode, address and pointers captured at byte boundaries.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q     <= 8'h00;
      addr_q   <= 24'h000000;
      ptr_q    <= 8'h00;
    end else if (byte_end) begin
      if (byte_q == 10'h000) begin
        op_q <= byte_in;
      end else if (byte_q < `SFO_LEN_ADDR) begin
        addr_q <= {addr_q[15:0], byte_in};
        ptr_q  <= byte_in;
      end else if (data_wr) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Page buffer with per-byte valid mask; overwrite keeps the last 256.
  logic [7:0]   page_mem [256];
  logic [255:0] valid_q;
  always_ff @(posedge clk) begin
    if (data_wr) begin
      page_mem[ptr_q] <= byte_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
    end else if (cs_fall && !wip_q) begin
      valid_q <= '0;
    end else if (data_wr) begin
      valid_q[ptr_q] <= 1'b1;
    end
  end

  // OTP storage: three areas of 256 bytes; area zero reads erased.
  logic [7:0] otp_mem [768];
  wire  [1:0] rd_area = rd_ptr_q[9:8];
  wire  [9:0] rd_idx  = {rd_area - 2'h1, rd_ptr_q[7:0]};
  wire  [7:0] otp_rd  = (rd_area == 2'h0) ? `SFO_ERASED : otp_mem[rd_idx];

  // Status byte seen by a status read.
  wire [7:0] status;
  assign status[`SFO_ST_WIP]             = wip_q;
  assign status[`SFO_ST_WEL]             = wel_q;
  assign status[`SFO_ST_BP_LO+2:`SFO_ST_BP_LO] = protect_level;
  assign status[`SFO_ST_TB]              = protect_top_bottom_select;
  assign status[`SFO_ST_SEC]             = protect_granularity_select;
  assign status[7]                       = 1'b0;
  wire [7:0] out_byte = rd_sr ? status : otp_rd;

  // Output shifter driven on falling edges; a new byte loads on a boundary.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_q <= 10'h000;
      out_q    <= 8'h00;
      so_q     <= 1'b0;
      oe_n_q   <= 1'b1;
    end else begin
      if (byte_end && byte_q == 10'h003) begin
        rd_ptr_q <= {addr_q[1:0], byte_in};
      end else if (sck_dn && rd_otp && bit_q == 3'h0) begin
        rd_ptr_q <= rd_ptr_q + 10'h001;
      end
      if (sck_dn && rd_on) begin
        if (bit_q == 3'h0) begin
          so_q  <= out_byte[7];
          out_q <= {out_byte[6:0], 1'b0};
        end else begin
          so_q  <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end
      oe_n_q <= ~(rd_on & ~oe_n_q | rd_on & sck_dn);
    end
  end

  // Protection: level 0 none, 7 all, else a power-of-two run at one end.
  function automatic logic prot_hit(input logic [7:0] sect);
    logic [8:0] n;
    n = 9'h000;
    if (protect_level == 3'h7) begin
      n = `SFO_NUM_SECT;
    end else if (protect_level != 3'h0) begin
      if (protect_granularity_select) begin
        n = (protect_level >= 3'h4) ? 9'h008 : (9'h001 << (protect_level - 3'h1));
      end else begin
        n = (protect_level >= 3'h5) ? 9'h100 : (9'h010 << (protect_level - 3'h1));
      end
    end
    if (protect_top_bottom_select) begin
      prot_hit = ({1'b0, sect} < n);
    end else begin
      prot_hit = ({1'b0, sect} >= (`SFO_NUM_SECT - n));
    end
  endfunction

  wire [7:0] sect     = addr_q[19:12];
  wire [7:0] blk_sect = {sect[7:3], 3'h0};
  wire       blk_prot = prot_hit(blk_sect) | prot_hit(blk_sect + `SFO_SECT_PER_BLK - 8'h01);
  wire [1:0] area     = addr_q[9:8];
  wire       area_ok  = (addr_q[23:16] == 8'h00) & (addr_q[15:10] == 6'h00) & (area != 2'h0);
  wire [2:0] locks    = {otp_area_three_lock, otp_area_two_lock, otp_area_one_lock};
  wire       area_lk  = locks[area - 2'h1];

  // Frame length checks at chip-select rise.
  wire whole    = (bit_q == 3'h0);
  wire len_op   = whole & (byte_q == `SFO_LEN_OPCODE);
  wire len_addr = whole & (byte_q == `SFO_LEN_ADDR);
  wire len_data = whole & (byte_q >= `SFO_LEN_DUMMY);
  wire may_go   = cs_rise & wel_q & ~wip_q;

  wire go_pp = may_go & (op_q == `SFO_OP_PAGE_PROG) & len_data & ~prot_hit(sect);
  wire go_po = may_go & (op_q == `SFO_OP_OTP_PROG) & len_data & area_ok & ~area_lk;
  wire go_se = may_go & (op_q == `SFO_OP_SECT_ERS) & len_addr & ~prot_hit(sect);
  wire go_be = may_go & (op_q == `SFO_OP_BLK_ERS) & len_addr & ~blk_prot;
  wire go_oe = may_go & (op_q == `SFO_OP_OTP_ERASE) & len_op & ~&locks;
  wire go    = go_pp | go_po | go_se | go_be | go_oe;

  // Sequencer state.
  sfo_state_t  st_q;
  sfo_kind_t   kind_q;
  logic [9:0]  walk_q;
  logic [31:0] tmr_q;
  logic [1:0]  po_area_q;
  logic [15:0] pg_q;
  logic        ers_q;
  logic        ers_blk_q;
  logic [23:0] ers_addr_q;

  // Flush step: page bytes go out through the FIFO, OTP bytes stay inside.
  wire        fl      = (st_q == SFO_FLUSH);
  wire        vbit    = valid_q[walk_q[7:0]];
  wire        fifo_rdy;
  sfo_wr_t    fifo_in;
  sfo_wr_t    fifo_out;
  wire        push    = fl & (kind_q == SFO_K_PP) & vbit;
  wire        step    = fl & (~push | fifo_rdy);
  wire [9:0]  last    = (kind_q == SFO_K_OE) ? 10'h2FF : 10'h0FF;
  wire [9:0]  po_idx  = {po_area_q - 2'h1, walk_q[7:0]};
  wire [1:0]  oe_area = walk_q[9:8] + 2'h1;
  wire        oe_wr   = fl & (kind_q == SFO_K_OE) & ~locks[walk_q[9:8]];
  wire        po_wr   = fl & (kind_q == SFO_K_PO) & vbit;
  wire [31:0] t_load  = (kind_q == SFO_K_SE || kind_q == SFO_K_OE) ? SE_CYCLES :
                        (kind_q == SFO_K_BE) ? BE_CYCLES : PP_CYCLES;
  assign fifo_in = {pg_q, walk_q[7:0], page_mem[walk_q[7:0]]};

  // OTP array writes; programming can only clear bits.
  always_ff @(posedge clk) begin
    if (po_wr) begin
      otp_mem[po_idx] <= otp_mem[po_idx] & page_mem[walk_q[7:0]];
    end else if (oe_wr && oe_area != 2'h0) begin
      otp_mem[walk_q] <= `SFO_ERASED;
    end
  end

  // Cycle sequencer; busy from chip-select rise to the end of timing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q       <= SFO_IDLE;
      kind_q     <= SFO_K_PP;
      walk_q     <= 10'h000;
      tmr_q      <= 32'h00000000;
      po_area_q  <= 2'h0;
      pg_q       <= 16'h0000;
      wip_q      <= 1'b0;
      ers_q      <= 1'b0;
      ers_blk_q  <= 1'b0;
      ers_addr_q <= 24'h000000;
    end else begin
      ers_q <= 1'b0;
      case (st_q)
        SFO_IDLE: begin
          if (go) begin
            wip_q     <= 1'b1;
            walk_q    <= 10'h000;
            po_area_q <= area;
            pg_q      <= addr_q[23:8];
            kind_q    <= go_pp ? SFO_K_PP : go_po ? SFO_K_PO : go_se ? SFO_K_SE :
                         go_be ? SFO_K_BE : SFO_K_OE;
            if (go_se || go_be) begin
              ers_q      <= 1'b1;
              ers_blk_q  <= go_be;
              ers_addr_q <= go_be ? {addr_q[23:15], 15'h0000} : {addr_q[23:12], 12'h000};
              st_q       <= SFO_TIME;
            end else begin
              st_q <= SFO_FLUSH;
            end
          end
          tmr_q <= 32'h00000000;
        end
        SFO_FLUSH: begin
          if (step) begin
            walk_q <= walk_q + 10'h001;
            if (walk_q == last) begin
              st_q <= SFO_TIME;
            end
          end
        end
        SFO_TIME: begin
          // Busy also covers bytes still queued for the array, so a slow far side cannot outlast it.
          if (tmr_q >= t_load - 32'h00000001 && !mem_wr_valid) begin
            st_q  <= SFO_IDLE;
            wip_q <= 1'b0;
          end
          tmr_q <= tmr_q + 32'h00000001;
        end
        default: begin
          st_q <= SFO_IDLE;
        end
      endcase
    end
  end

  // Write enable latch; a started cycle clears it at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (go) begin
      wel_q <= 1'b0;
    end else if (cs_rise && !wip_q && len_op) begin
      if (op_q == `SFO_OP_WREN) begin
        wel_q <= 1'b1;
      end else if (op_q == `SFO_OP_WRDI) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Stall when the array side holds back; the walk waits on FIFO space.
  sfo_fifo #(
    .WIDTH ($bits(sfo_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (fifo_in),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (fifo_out)
  );

  assign mem_wr_addr        = fifo_out.addr;
  assign mem_wr_data        = fifo_out.data;
  assign spi_so             = so_q;
  assign spi_so_oe_n        = oe_n_q;
  assign write_in_progress  = wip_q;
  assign write_enable_latch = wel_q;
  assign erase_req          = ers_q;
  assign erase_block        = ers_blk_q;
  assign erase_addr         = ers_addr_q;
endmodule

//--- logic/sfo_fifo.sv
`timescale 1ns/100ps
module sfo_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
    $error("sfo_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count.
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  // Storage has no reset; only occupancy does.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointer and count update.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + AW'(push);
      rd_q  <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- logic/sfo_map.svh
`ifndef SFO_MAP_SVH
`define SFO_MAP_SVH
// Instruction codes.
`define SFO_OP_WREN      8'h06
`define SFO_OP_WRDI      8'h04
`define SFO_OP_RDSR      8'h05
`define SFO_OP_OTP_READ  8'h48
`define SFO_OP_OTP_ERASE 8'h44
`define SFO_OP_OTP_PROG  8'h42
`define SFO_OP_PAGE_PROG 8'h02
`define SFO_OP_SECT_ERS  8'h20
`define SFO_OP_BLK_ERS   8'h52
// Frame lengths in whole bytes.
`define SFO_LEN_OPCODE   10'h001
`define SFO_LEN_ADDR     10'h004
`define SFO_LEN_DUMMY    10'h005
// Status byte field positions.
`define SFO_ST_WIP       0
`define SFO_ST_WEL       1
`define SFO_ST_BP_LO     2
`define SFO_ST_TB        5
`define SFO_ST_SEC       6
// Erased byte value.
`define SFO_ERASED       8'hFF
// Self-timed cycle lengths in microseconds, and clock rate.
`define SFO_T_PP_US      700
`define SFO_T_SE_US      60000
`define SFO_T_BE_US      200000
`define SFO_CLK_MHZ      50
// Sectors in the array, and sectors per 32 KB block.
`define SFO_NUM_SECT     9'h100
`define SFO_SECT_PER_BLK 8'h08
`endif

//--- logic/sfo_pkg.sv
package sfo_pkg;
  // One byte headed for the main array.
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } sfo_wr_t;

  // Self-timed cycle sequencer.
  typedef enum logic [1:0] {
    SFO_IDLE  = 2'b00,
    SFO_FLUSH = 2'b01,
    SFO_TIME  = 2'b10
  } sfo_state_t;

  // Kind of the running cycle.
  typedef enum logic [2:0] {
    SFO_K_PP = 3'b000,
    SFO_K_PO = 3'b001,
    SFO_K_SE = 3'b010,
    SFO_K_BE = 3'b011,
    SFO_K_OE = 3'b100
  } sfo_kind_t;
endpackage
